/* pkg/ptm_regs.vh */
// register indices, field positions, reset values and masks of the paired timer
`ifndef PTM_REGS_VH
`define PTM_REGS_VH
`define PTM_IDX_LOW_COUNT   10'h106
`define PTM_IDX_HOLD        10'h108
`define PTM_IDX_HIGH_COUNT  10'h10A
`define PTM_IDX_LOW_PERIOD  10'h10C
`define PTM_IDX_HIGH_PERIOD 10'h10E
`define PTM_IDX_LOW_CTRL    10'h110
`define PTM_IDX_HIGH_CTRL   10'h112
`define PTM_IDX_STATUS      10'h114
`define PTM_BIT_ON          15
`define PTM_BIT_SIDL        13
`define PTM_BIT_GATE        6
`define PTM_BIT_PS_HI       5
`define PTM_BIT_PS_LO       4
`define PTM_BIT_PAIR        3
`define PTM_BIT_CS          1
`define PTM_ST_LOW_FLAG     0
`define PTM_ST_HIGH_FLAG    1
`define PTM_ST_LOW_IE       8
`define PTM_ST_HIGH_IE      9
`define PTM_LOW_CTRL_MASK   16'hA07A
`define PTM_HIGH_CTRL_MASK  16'hA072
`define PTM_RST_PERIOD      16'hFFFF
`define PTM_RST_COUNT       16'h0000
`define PTM_RST_CTRL        16'h0000
`define PTM_PS_DIV1         8'h00
`define PTM_PS_DIV8         8'h07
`define PTM_PS_DIV64        8'h3F
`define PTM_PS_DIV256       8'hFF
`endif

/* src/ptm_timer.v */
// paired 16/32-bit timer with ahb-lite register slave
`timescale 1ns/1ns
`include "ptm_regs.vh"
module ptm_timer (
   input  wire        hclk,                   // bus and timer clock
   input  wire        hresetn,                // async reset, active low
   input  wire        clk_en,                 // freezes all state when low
   input  wire        hsel,                   // slave select
   input  wire [31:0] haddr,                  // byte address
   input  wire [1:0]  htrans,                 // transfer type
   input  wire        hwrite,                 // write when high
   input  wire [2:0]  hsize,                  // transfer size
   input  wire [31:0] hwdata,                 // write data
   input  wire        hready,                 // bus ready in
   output reg  [31:0] hrdata,                 // read data
   output reg         hreadyout,              // slave ready
   output reg         hresp,                  // always okay
   input  wire        cpu_idle,               // cpu idle state
   input  wire        low_timer_clock_gate_pin, // low clock or gate pin
   input  wire        high_timer_clock_pin,   // high clock or gate pin
   output reg         low_irq,                // low flag and enable
   output reg         high_irq,               // high flag and enable
   output reg         adc_trigger             // one-cycle match pulse
);

   reg  [15:0] low_count_reg;
   reg  [15:0] high_count_reg;
   reg  [15:0] high_word_holding_reg;
   reg  [15:0] low_period_reg;
   reg  [15:0] high_period_reg;
   reg  [15:0] low_timer_control;
   reg  [15:0] high_timer_control;
   reg         low_irq_flag;
   reg         high_timer_irq_flag;
   reg         low_irq_enable;
   reg         high_timer_irq_enable;
   reg         wr_pend;
   reg  [9:0]  wr_idx;
   reg         rd_pend;
   reg  [9:0]  rd_idx;
   reg         low_tick;
   reg  [15:0] next_low;
   reg  [15:0] next_high;
   reg  [31:0] rd_mux;

   wire        pair_32bit_select;
   wire [31:0] eff_ctrl;
   wire [1:0]  pin_raw;
   wire [1:0]  pre_pulse;
   wire [1:0]  gate_fall;
   wire [1:0]  pre_clr;
   wire        accept;
   wire        wr_low;
   wire        wr_high;
   wire        wr_hold;
   wire        wr_lctl;
   wire        wr_hctl;
   wire        wr_st;
   wire        on_cleared;
   wire [31:0] cnt32;
   wire [31:0] combined_period_value;
   wire        match32;
   wire        match_lo;
   wire        match_hi;
   wire        set_lo;
   wire        set_hi;

   assign pair_32bit_select = low_timer_control[`PTM_BIT_PAIR];
   // high half follows low controls in paired mode
   assign eff_ctrl[15:0]  = low_timer_control;
   assign eff_ctrl[31:16] = pair_32bit_select ? low_timer_control :
                            high_timer_control;
   assign pin_raw = {high_timer_clock_pin, low_timer_clock_gate_pin};

   // bus decode
   assign accept  = hsel & hready & htrans[1] & (hsize == 3'b010);
   assign wr_low  = wr_pend & (wr_idx == `PTM_IDX_LOW_COUNT);
   assign wr_high = wr_pend & (wr_idx == `PTM_IDX_HIGH_COUNT);
   assign wr_hold = wr_pend & (wr_idx == `PTM_IDX_HOLD);
   assign wr_lctl = wr_pend & (wr_idx == `PTM_IDX_LOW_CTRL);
   assign wr_hctl = wr_pend & (wr_idx == `PTM_IDX_HIGH_CTRL);
   assign wr_st   = wr_pend & (wr_idx == `PTM_IDX_STATUS);

   // timer-on going from one to zero on either control
   assign on_cleared =
      (wr_lctl & low_timer_control[`PTM_BIT_ON] & ~hwdata[`PTM_BIT_ON]) |
      (wr_hctl & high_timer_control[`PTM_BIT_ON] & ~hwdata[`PTM_BIT_ON]);
   assign pre_clr[1] = wr_low | wr_high | on_cleared;
   assign pre_clr[0] = pre_clr[1] & low_timer_control[`PTM_BIT_ON];

   // per-half pin sync, clock source, gate and prescaler
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_half
         wire [15:0] c = eff_ctrl[i*16 +: 16];
         reg         s1;
         reg         s2;
         reg         s3;
         reg  [7:0]  pre;
         reg  [7:0]  mask;
         wire        run;
         wire        gated;
         wire        src;
         wire        hit;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end else if (clk_en) begin
               s1 <= pin_raw[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         assign run   = c[`PTM_BIT_ON] & ~(cpu_idle & c[`PTM_BIT_SIDL]);
         assign gated = c[`PTM_BIT_GATE] & ~c[`PTM_BIT_CS];
         // external edges only after sync, no async path
         assign src   = c[`PTM_BIT_CS] ? (s2 & ~s3) :
                        (gated ? s2 : 1'b1);
         always @* begin
            case (c[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO])
               2'b00:   mask = `PTM_PS_DIV1;
               2'b01:   mask = `PTM_PS_DIV8;
               2'b10:   mask = `PTM_PS_DIV64;
               default: mask = `PTM_PS_DIV256;
            endcase
         end
         assign hit = run & src & ((pre & mask) == mask);
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               pre <= 8'h00;
            end else if (clk_en) begin
               if (pre_clr[i]) begin
                  pre <= 8'h00;
               end else if (run & src) begin
                  pre <= hit ? 8'h00 : pre + 8'h01;
               end
            end
         end
         assign pre_pulse[i] = hit;
         assign gate_fall[i] = c[`PTM_BIT_ON] & gated & s3 & ~s2;
      end
   endgenerate

   // low prescaler output resynchronised, high used directly
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_tick <= 1'b0;
      end else if (clk_en) begin
         low_tick <= pre_pulse[0];
      end
   end

   assign cnt32 = {high_count_reg, low_count_reg};
   assign combined_period_value = {high_period_reg, low_period_reg};
   assign match32  = pair_32bit_select & low_tick &
                     (cnt32 == combined_period_value);
   assign match_lo = ~pair_32bit_select & low_tick &
                     (low_count_reg == low_period_reg);
   // high prescaler ignored while paired
   assign match_hi = ~pair_32bit_select & pre_pulse[1] &
                     (high_count_reg == high_period_reg);

   // count next state, bus writes beat increments
   always @* begin
      next_low  = low_count_reg;
      next_high = high_count_reg;
      if (pair_32bit_select) begin
         if (low_tick) begin
            {next_high, next_low} = match32 ? 32'h00000000 :
                                    cnt32 + 32'h00000001;
         end
      end else begin
         if (low_tick) begin
            next_low = match_lo ? 16'h0000 : low_count_reg + 16'h0001;
         end
         if (pre_pulse[1]) begin
            next_high = match_hi ? 16'h0000 : high_count_reg + 16'h0001;
         end
      end
      // control writes never reach the counts
      if (wr_low) begin
         next_low = hwdata[15:0];
         if (pair_32bit_select) begin
            next_high = high_word_holding_reg;
         end
      end
      if (wr_high) begin
         next_high = hwdata[15:0];
      end
   end

   // flag sources
   assign set_lo = match_lo | (~pair_32bit_select & gate_fall[0]);
   assign set_hi = match32 | match_hi |
                   (pair_32bit_select ? gate_fall[0] : gate_fall[1]);

   // registers, flags and outputs
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_count_reg         <= `PTM_RST_COUNT;
         high_count_reg        <= `PTM_RST_COUNT;
         high_word_holding_reg <= `PTM_RST_COUNT;
         low_period_reg        <= `PTM_RST_PERIOD;
         high_period_reg       <= `PTM_RST_PERIOD;
         low_timer_control     <= `PTM_RST_CTRL;
         high_timer_control    <= `PTM_RST_CTRL;
         low_irq_flag          <= 1'b0;
         high_timer_irq_flag   <= 1'b0;
         low_irq_enable        <= 1'b0;
         high_timer_irq_enable <= 1'b0;
         low_irq               <= 1'b0;
         high_irq              <= 1'b0;
         adc_trigger           <= 1'b0;
      end else if (clk_en) begin
         low_count_reg  <= next_low;
         high_count_reg <= next_high;
         if (wr_hold) begin
            high_word_holding_reg <= hwdata[15:0];
         end else if (rd_pend & (rd_idx == `PTM_IDX_LOW_COUNT)) begin
            high_word_holding_reg <= high_count_reg;
         end
         if (wr_pend & (wr_idx == `PTM_IDX_LOW_PERIOD)) begin
            low_period_reg <= hwdata[15:0];
         end
         if (wr_pend & (wr_idx == `PTM_IDX_HIGH_PERIOD)) begin
            high_period_reg <= hwdata[15:0];
         end
         if (wr_lctl) begin
            low_timer_control <= hwdata[15:0] & `PTM_LOW_CTRL_MASK;
         end
         if (wr_hctl) begin
            high_timer_control <= hwdata[15:0] & `PTM_HIGH_CTRL_MASK;
         end
         if (wr_st) begin
            low_irq_enable        <= hwdata[`PTM_ST_LOW_IE];
            high_timer_irq_enable <= hwdata[`PTM_ST_HIGH_IE];
         end
         // write one to clear, a new event wins
         low_irq_flag <= set_lo |
            (low_irq_flag & ~(wr_st & hwdata[`PTM_ST_LOW_FLAG]));
         high_timer_irq_flag <= set_hi |
            (high_timer_irq_flag & ~(wr_st & hwdata[`PTM_ST_HIGH_FLAG]));
         low_irq  <= low_irq_flag & low_irq_enable;
         high_irq <= high_timer_irq_flag & high_timer_irq_enable;
         adc_trigger <= match32 | match_hi;
      end
   end

   // read mux, unmapped reads return zero
   always @* begin
      rd_mux = 32'h00000000;
      case (rd_idx)
         `PTM_IDX_LOW_COUNT:   rd_mux[15:0] = low_count_reg;
         `PTM_IDX_HOLD:        rd_mux[15:0] = high_word_holding_reg;
         `PTM_IDX_HIGH_COUNT:  rd_mux[15:0] = high_count_reg;
         `PTM_IDX_LOW_PERIOD:  rd_mux[15:0] = low_period_reg;
         `PTM_IDX_HIGH_PERIOD: rd_mux[15:0] = high_period_reg;
         `PTM_IDX_LOW_CTRL:    rd_mux[15:0] = low_timer_control;
         `PTM_IDX_HIGH_CTRL:   rd_mux[15:0] = high_timer_control;
         `PTM_IDX_STATUS: begin
            rd_mux[`PTM_ST_LOW_FLAG]  = low_irq_flag;
            rd_mux[`PTM_ST_HIGH_FLAG] = high_timer_irq_flag;
            rd_mux[`PTM_ST_LOW_IE]    = low_irq_enable;
            rd_mux[`PTM_ST_HIGH_IE]   = high_timer_irq_enable;
         end
         default: rd_mux = 32'h00000000;
      endcase
   end

   // ahb-lite slave: writes no wait, reads one wait state
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend   <= 1'b0;
         wr_idx    <= 10'h000;
         rd_pend   <= 1'b0;
         rd_idx    <= 10'h000;
         hrdata    <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else if (clk_en) begin
         hresp   <= 1'b0;
         wr_pend <= accept & hwrite;
         if (accept) begin
            wr_idx <= haddr[11:2];
            rd_idx <= haddr[11:2];
         end
         if (rd_pend) begin
            rd_pend   <= 1'b0;
            hrdata    <= rd_mux;
            hreadyout <= 1'b1;
         end else if (accept & ~hwrite) begin
            rd_pend   <= 1'b1;
            hreadyout <= 1'b0;
         end
      end
   end

endmodule // ptm_timer

/* test/ptm_timer_props.sv */
// bus and port assertions of the paired timer
`timescale 1ns/1ns
`include "ptm_regs.vh"
module ptm_timer_props (
   input wire        hclk,                     // clock
   input wire        hresetn,                  // reset, active low
   input wire        clk_en,                   // run enable
   input wire        hsel,                     // select
   input wire [31:0] haddr,                    // address
   input wire [1:0]  htrans,                   // transfer type
   input wire        hwrite,                   // write
   input wire [2:0]  hsize,                    // size
   input wire [31:0] hwdata,                   // write data
   input wire        hready,                   // bus ready
   input wire [31:0] hrdata,                   // read data
   input wire        hreadyout,                // slave ready
   input wire        hresp,                    // response
   input wire        cpu_idle,                 // idle
   input wire        low_timer_clock_gate_pin, // low pin
   input wire        high_timer_clock_pin,     // high pin
   input wire        low_irq,                  // low irq
   input wire        high_irq,                 // high irq
   input wire        adc_trigger               // trigger pulse
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn || !clk_en);
   sequence s_rd;
      hsel && hready && htrans[1] && !hwrite && hsize == 3'b010;
   endsequence
   sequence s_wr;
      hsel && hready && htrans[1] && hwrite && hsize == 3'b010;
   endsequence
   sequence s_rd_done;
      !hreadyout ##1 hreadyout;
   endsequence
   a_read_one_wait: assert property (s_rd |=> s_rd_done) else $error("read wait wrong");
   a_write_no_wait: assert property (s_wr |=> hreadyout) else $error("write stalled");
   a_resp_always_okay: assert property (hresp == 1'b0) else $error("response not okay");
   a_wait_has_cause: assert property ($fell(hreadyout) |-> $past(hsel && hready && htrans[1]
      && !hwrite)) else $error("wait without read");
   a_rdata_holds: assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
   a_upper_half_zero: assert property ($rose(hreadyout) |-> hrdata[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_unmapped_reads_zero: assert property (s_rd ##0 (haddr[11:2] == 10'h000)
      |-> ##2 hrdata == 32'h00000000) else $error("unmapped read not zero");
   a_ctrl_bits_masked: assert property (s_rd ##0 (haddr[11:2] == `PTM_IDX_LOW_CTRL) |-> ##2
      (hrdata[15:0] & ~`PTM_LOW_CTRL_MASK) == 16'h0000) else $error("control bits unmasked");
endmodule // ptm_timer_props
bind ptm_timer ptm_timer_props u_props (.*);

/* test/ptm_pin_model.sv */
// far-side model of the external clock and gate pin
`timescale 1ns/1ns
module ptm_pin_model (
   input wire hclk, // timer clock
   output reg pin   // clock or gate level
);
   initial pin = 1'b0;
   task pulses(input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            repeat (4) @(posedge hclk);
            pin <= 1'b1;
            repeat (4) @(posedge hclk);
            pin <= 1'b0;
         end
      end
   endtask
   task gate(input integer n);
      begin
         @(posedge hclk);
         pin <= 1'b1;
         repeat (n) @(posedge hclk);
         pin <= 1'b0;
      end
   endtask
endmodule // ptm_pin_model

/* test/ptm_timer_test.sv */
// self-checking bench of the paired timer
`timescale 1ns/1ns
`include "ptm_regs.vh"
module ptm_timer_test;
   reg         hclk, hresetn, hsel, hwrite, cpu_idle;
   reg  [31:0] haddr, hwdata, rd_val;
   reg  [1:0]  htrans;
   reg  [2:0]  hsize;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, low_irq, high_irq, adc_trigger, pin, pin_hi;
   integer     error_cnt, checks_done, cyc, n, ps;
   ptm_timer dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_idle(cpu_idle),
      .low_timer_clock_gate_pin(pin), .high_timer_clock_pin(pin_hi), .low_irq(low_irq),
      .high_irq(high_irq), .adc_trigger(adc_trigger));
   ptm_pin_model pm (.hclk(hclk), .pin(pin));
   ptm_pin_model pm_hi (.hclk(hclk), .pin(pin_hi));
   task print_verdict;
      begin
         if (error_cnt == 0 && checks_done > 0)
            $display("No errors found");
         else
            $display("Errors were found");
         $finish;
      end
   endtask
   task chk(input string name, input [31:0] seen, input [31:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
         end
      end
   endtask
   task xfer(input [9:0] idx, input wr, input [31:0] d);
      begin
         @(posedge hclk);
         haddr <= {20'h00000, idx, 2'b00};
         htrans <= 2'b10;
         hwrite <= wr;
         do @(negedge hclk); while (!hreadyout);
         @(posedge hclk);
         htrans <= 2'b00;
         hwdata <= d;
         do @(negedge hclk); while (!hreadyout);
         rd_val = hrdata;
         @(posedge hclk);
      end
   endtask
   task rdchk(input string name, input [9:0] idx, input [31:0] exp);
      begin
         xfer(idx, 1'b0, 32'h00000000);
         chk(name, rd_val, exp);
      end
   endtask
   task next_pulse(output integer k);
      begin
         k = 0;
         do begin
            @(negedge hclk);
            k = k + 1;
         end while (adc_trigger !== 1'b1);
      end
   endtask
   task t_reset;
      begin
         rdchk("low period", `PTM_IDX_LOW_PERIOD, 32'h0000FFFF);
         rdchk("high period", `PTM_IDX_HIGH_PERIOD, 32'h0000FFFF);
         rdchk("low ctrl", `PTM_IDX_LOW_CTRL, 32'h00000000);
         rdchk("unmapped", 10'h000, 32'h00000000);
      end
   endtask
   task t_ctrl;
      begin
         xfer(`PTM_IDX_LOW_COUNT, 1'b1, 32'h00000055);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h0000FFFF);
         xfer(`PTM_IDX_HIGH_CTRL, 1'b1, 32'h0000FFFF);
         rdchk("low ctrl", `PTM_IDX_LOW_CTRL, 32'h0000A07A);
         rdchk("high ctrl", `PTM_IDX_HIGH_CTRL, 32'h0000A072);
         rdchk("count kept", `PTM_IDX_LOW_COUNT, 32'h00000055);
         xfer(`PTM_IDX_HIGH_CTRL, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00000008);
      end
   endtask
   task t_hold;
      begin
         xfer(`PTM_IDX_HOLD, 1'b1, 32'h00001234);
         xfer(`PTM_IDX_LOW_COUNT, 1'b1, 32'h00005678);
         rdchk("high count", `PTM_IDX_HIGH_COUNT, 32'h00001234);
         xfer(`PTM_IDX_HOLD, 1'b1, 32'h00000000);
         rdchk("low count", `PTM_IDX_LOW_COUNT, 32'h00005678);
         rdchk("holding", `PTM_IDX_HOLD, 32'h00001234);
         // holding still carries the captured high word; zero it first
         xfer(`PTM_IDX_HOLD, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_LOW_COUNT, 1'b1, 32'h00000000);
      end
   endtask
   task t_rate;
      begin
         xfer(`PTM_IDX_LOW_PERIOD, 1'b1, 32'h00000010);
         xfer(`PTM_IDX_HIGH_PERIOD, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_HIGH_CTRL, 1'b1, 32'h00008030);
         for (ps = 0; ps < 4; ps = ps + 1) begin
            xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00008008 | (ps << 4));
            next_pulse(n);
            next_pulse(n);
            chk("match spacing", n, 17 << ((ps == 3) ? 8 : 3 * ps));
         end
         xfer(`PTM_IDX_HIGH_CTRL, 1'b1, 32'h00000000);
      end
   endtask
   task t_idle;
      integer k;
      begin
         // first pass stops in idle, second pass counts through it
         for (k = 0; k < 2; k = k + 1) begin
            xfer(`PTM_IDX_LOW_CTRL, 1'b1, k ? 32'h00008008 : 32'h0000A008);
            next_pulse(n);
            fork
               next_pulse(n);
               begin
                  repeat (5) @(posedge hclk);
                  cpu_idle <= 1'b1;
                  repeat (40) @(posedge hclk);
                  cpu_idle <= 1'b0;
               end
            join
            chk("idle spacing", n, k ? 17 : 57);
         end
      end
   endtask
   task t_gate;
      begin
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00000008);
         xfer(`PTM_IDX_STATUS, 1'b1, 32'h00000003);
         xfer(`PTM_IDX_LOW_COUNT, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00008048);
         // gate shorter than the combined period, so only the falling edge flags
         pm.gate(12);
         repeat (6) @(posedge hclk);
         rdchk("gated count", `PTM_IDX_LOW_COUNT, 32'h0000000C);
         rdchk("gate flag", `PTM_IDX_STATUS, 32'h00000002);
         xfer(`PTM_IDX_STATUS, 1'b1, 32'h00000002);
         rdchk("flag cleared", `PTM_IDX_STATUS, 32'h00000000);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00000008);
         xfer(`PTM_IDX_LOW_COUNT, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h0000800A);
         pm.pulses(5);
         repeat (6) @(posedge hclk);
         rdchk("edge count", `PTM_IDX_LOW_COUNT, 32'h00000005);
      end
   endtask
   task t_irq;
      begin
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_STATUS, 1'b1, 32'h00000103);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00008000);
         repeat (40) @(negedge hclk);
         chk("low irq", low_irq, 1'b1);
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00008008);
         xfer(`PTM_IDX_STATUS, 1'b1, 32'h00000203);
         repeat (40) @(negedge hclk);
         chk("high irq", high_irq, 1'b1);
         chk("low irq off", low_irq, 1'b0);
      end
   endtask
   task t_high;
      begin
         xfer(`PTM_IDX_LOW_CTRL, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_HIGH_PERIOD, 1'b1, 32'h0000FFFF);
         xfer(`PTM_IDX_HIGH_COUNT, 1'b1, 32'h00000000);
         xfer(`PTM_IDX_HIGH_CTRL, 1'b1, 32'h00008002);
         pm_hi.pulses(3);
         repeat (6) @(posedge hclk);
         rdchk("high edge count", `PTM_IDX_HIGH_COUNT, 32'h00000003);
      end
   endtask
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         print_verdict;
      end
   end
   initial begin
      {hresetn, hsel, hwrite, cpu_idle, htrans} = 6'h00;
      {haddr, hwdata, rd_val} = 96'h0;
      hsize = 3'b010;
      {error_cnt, checks_done, cyc} = 96'h0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      t_reset;
      t_ctrl;
      t_hold;
      t_rate;
      t_idle;
      t_gate;
      t_irq;
      t_high;
      print_verdict;
   end
endmodule // ptm_timer_test
